// ===== dcrp_pkg.sv
// shared constants and types for the dc-restore offset field packer
package dcrp_pkg;

  // offset field geometry
  localparam int unsigned OFS_WORDS = 32'h226;             // 550 table entries
  localparam int unsigned OFS_FIELD_BITS = 32'h1130;       // 4400 bits
  localparam logic [9:0] OFS_LAST = 10'h225;               // last word offset, 549
  localparam logic [12:0] OFS_START_BIT = 13'h090;         // packet bit 144
  localparam logic [12:0] OFS_END_BIT = 13'h11bf;          // packet bit 4543
  localparam logic [12:0] OFS_LAST_START = 13'h11b8;       // start bit of last entry
  localparam int unsigned ENTRY_BITS = 32'h8;
  localparam int unsigned TBL_WORD_BITS = 32'h10;          // bus memory word width

  // detector-index grouping of the field
  localparam logic [5:0] GROUP_WORDS = 6'h37;              // 55 entries per group
  localparam logic [5:0] GROUP_LAST_SLOT = 6'h36;
  localparam logic [3:0] GROUP_COUNT = 4'ha;
  localparam logic [5:0] PHOTO_FIRST_SLOT = 6'h2b;         // bands 31-36 post/pre pairs
  localparam logic [5:0] DUAL_LOW_A_SLOT = 6'h17;
  localparam logic [5:0] DUAL_HIGH_A_SLOT = 6'h18;
  localparam logic [5:0] DUAL_LOW_B_SLOT = 6'h19;
  localparam logic [5:0] DUAL_HIGH_B_SLOT = 6'h1a;

  // earth encoder time field
  localparam int unsigned ENC_WORDS = 32'h4e;              // 78 words
  localparam int unsigned ENC_DATA_WORDS = 32'h18;         // 24 data words
  localparam int unsigned ENC_FILL_WORDS = 32'h36;         // 54 zero words
  localparam logic [9:0] ENC_LAST = 10'h04d;
  localparam logic [9:0] ENC_DATA_LIMIT = 10'h018;
  localparam logic [4:0] ENC_DATA_LAST = 5'h17;
  localparam logic [12:0] ENC_START_BIT = 13'h090;         // packet bit 144 of next packet
  localparam logic [6:0] ENC_GROUP_LAST = 7'h63;           // 100th pulse closes a group
  localparam logic [15:0] ENC_FILL_VALUE = 16'h0000;

  // timing: encoder times are kept in microsecond ticks
  localparam int unsigned CLK_PERIOD_NS = 32'h14;          // 20 ns
  localparam int unsigned TICK_NS = 32'h3e8;               // 1 us
  localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ENC_PULSE_PERIOD_NS = 32'h2c060; // 180.32 us nominal
  localparam int unsigned FRAME_PERIOD_NS = 32'h51615;     // 333.333 us
  localparam int unsigned ENC_LEAD_FRAMES = 32'h2;         // count starts 2 periods early

  typedef enum logic [2:0] {
    DCRP_PLAIN = 3'h0,
    DCRP_POSTAMP = 3'h1,
    DCRP_PREAMP = 3'h2,
    DCRP_LOW = 3'h3,
    DCRP_HIGH = 3'h4,
    DCRP_ENC = 3'h5
  } dcrp_kind_t;

  typedef struct packed {
    dcrp_kind_t kind;
    logic [12:0] pkt_bit;
    logic [15:0] data;
  } dcrp_word_t;

  typedef enum logic [1:0] {
    DCRP_IDLE = 2'h0,
    DCRP_OFFS = 2'h1,
    DCRP_EARTH = 2'h2
  } dcrp_state_t;

endpackage : dcrp_pkg

// ===== dcrp_fifo.sv
// parameterised fifo with a registered output stage
`timescale 1ns/1ps
`default_nettype none
module dcrp_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_sys_in,             // system clock
  input wire logic rst_n_in,               // async reset, active low
  input wire logic s_valid_in,             // write side valid
  output logic s_ready_out,                // write side ready
  input wire logic [WIDTH-1:0] s_data_in,  // write data
  output logic m_valid_out,                // read side valid
  input wire logic m_ready_in,             // read side ready
  output logic [WIDTH-1:0] m_data_out      // read data, registered
);
  localparam int unsigned AW = $clog2(DEPTH);

  // elaboration check: pointers wrap on their own only at a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("dcrp_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  // handshake decode; the output stage counts as one extra slot
  wire push = s_valid_in && s_ready_out;
  wire take = m_valid_out && m_ready_in;
  wire load = (count != '0) && (!m_valid_out || take);
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(load);

  // storage write
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= s_data_in;
    end
  end

  // pointers and counters
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      s_ready_out <= 1'b1;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(load);
      count <= next_count;
      s_ready_out <= next_count < (AW+1)'(DEPTH); // honest full, back-pressure reaches source
    end
  end

  // output register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      m_valid_out <= 1'b0;
      m_data_out <= '0;
    end else begin
      m_valid_out <= load || (m_valid_out && !take);
      if (load) begin
        m_data_out <= mem[rd_ptr];
      end
    end
  end

endmodule : dcrp_fifo
`default_nettype wire

// ===== dcrp_packer.sv
// dc-restore offset field packer and earth encoder time field builder
`timescale 1ns/1ps
`default_nettype none
module dcrp_packer #(
  parameter int unsigned FIFO_DEPTH = 32
) (
  input wire logic clk_sys_in,                  // 50 MHz system clock
  input wire logic rst_n_in,                    // async reset, active low
  input wire logic scan_start_in,               // pulse, begins one scan's fields
  input wire logic dc_restore_on_in,            // level, computation enabled
  input wire logic calc_valid_in,               // pulse, new computed offset
  input wire logic [9:0] calc_addr_in,          // word offset of computed value
  input wire logic [7:0] calc_data_in,          // computed offset value
  input wire logic tbl_sel_gain_in,             // 0 offset table, 1 gain table
  input wire logic tbl_wr_in,                   // bus write strobe
  input wire logic tbl_rd_in,                   // bus read strobe
  input wire logic [9:0] tbl_addr_in,           // bus word offset
  input wire logic [15:0] tbl_wdata_in,         // bus write word
  output logic [15:0] tbl_rdata_out,            // bus read word
  output logic tbl_rvalid_out,                  // pulse, read word ready
  output logic tbl_err_out,                     // pulse, address out of range
  input wire logic earth_start_in,              // pulse, start encoder timing
  input wire logic enc_pulse_in,                // pulse, mirror encoder pulse
  output logic busy_out,                        // scan fields in progress
  output logic fmt_valid_out,                   // stream word valid
  input wire logic fmt_ready_in,                // formatter accepts word
  output dcrp_pkg::dcrp_word_t fmt_word_out     // stream word
);
  // elaboration check: refuse fifo depths below 2
  if (FIFO_DEPTH < 2) begin : g_depth_check
    $error("dcrp_packer: fifo depth too small");
  end

  logic [7:0] ofs_tbl [dcrp_pkg::OFS_WORDS];
  logic [7:0] gain_tbl [dcrp_pkg::OFS_WORDS];
  logic [15:0] earth_time [dcrp_pkg::ENC_DATA_WORDS];
  dcrp_pkg::dcrp_state_t state;
  logic [9:0] idx;
  logic [5:0] slot;
  logic [3:0] grp;
  logic fifo_ready;

  // bus and compute decode; the bus wins a same-cycle collision
  wire addr_ok = tbl_addr_in <= dcrp_pkg::OFS_LAST;
  wire [5:0] bus_slot = 6'(tbl_addr_in % 10'(dcrp_pkg::GROUP_WORDS));
  wire bus_photo_slot = bus_slot >= dcrp_pkg::PHOTO_FIRST_SLOT;
  wire ofs_bus_we = tbl_wr_in && !tbl_sel_gain_in && addr_ok;
  wire gain_bus_we = tbl_wr_in && tbl_sel_gain_in && addr_ok && !bus_photo_slot;
  wire calc_we = calc_valid_in && dc_restore_on_in && (calc_addr_in <= dcrp_pkg::OFS_LAST) && !ofs_bus_we;
  wire [9:0] ofs_wr_addr = ofs_bus_we ? tbl_addr_in : calc_addr_in;
  wire [7:0] ofs_wr_data = ofs_bus_we ? tbl_wdata_in[7:0] : calc_data_in;
  wire [7:0] bus_rd_byte = tbl_sel_gain_in ? (bus_photo_slot ? 8'h00 : gain_tbl[tbl_addr_in]) : ofs_tbl[tbl_addr_in];

  // offset and gain tables; the last computed value simply stays when the computation is off
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < dcrp_pkg::OFS_WORDS; i++) begin
        ofs_tbl[i] <= 8'h00;
        gain_tbl[i] <= 8'h00;
      end
    end else begin
      if (ofs_bus_we || calc_we) begin
        ofs_tbl[ofs_wr_addr] <= ofs_wr_data;
      end
      if (gain_bus_we) begin
        gain_tbl[tbl_addr_in] <= tbl_wdata_in[7:0];
      end
    end
  end

  // bus read answer one cycle after the strobe, entry in the low byte
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tbl_rdata_out <= 16'h0000;
      tbl_rvalid_out <= 1'b0;
      tbl_err_out <= 1'b0;
    end else begin
      tbl_rvalid_out <= tbl_rd_in && addr_ok;
      tbl_err_out <= (tbl_rd_in || tbl_wr_in) && !addr_ok;
      if (tbl_rd_in && addr_ok) begin
        tbl_rdata_out <= {8'h00, bus_rd_byte};
      end
    end
  end

  // earth encoder timing: microsecond ticks between every 100th encoder pulse
  logic enc_run;
  logic [5:0] tick_cnt;
  logic [15:0] time_cnt;
  logic [6:0] pulse_cnt;
  logic [4:0] enc_idx;
  wire tick = tick_cnt == 6'(dcrp_pkg::TICK_CYCLES - 1);
  wire group_done = enc_run && enc_pulse_in && (pulse_cnt == dcrp_pkg::ENC_GROUP_LAST);
  wire [15:0] time_inc = (tick && time_cnt != 16'hffff) ? time_cnt + 16'h0001 : time_cnt; // saturates

  // earth_start_in is expected two frame periods ahead of earth collection
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enc_run <= 1'b0;
      tick_cnt <= 6'h00;
      time_cnt <= 16'h0000;
      pulse_cnt <= 7'h00;
      enc_idx <= 5'h00;
    end else if (earth_start_in) begin
      enc_run <= 1'b1;
      tick_cnt <= 6'h00;
      time_cnt <= 16'h0000;
      pulse_cnt <= 7'h00;
      enc_idx <= 5'h00;
    end else if (enc_run) begin
      tick_cnt <= tick ? 6'h00 : tick_cnt + 6'h01;
      time_cnt <= group_done ? 16'h0000 : time_inc;
      pulse_cnt <= group_done ? 7'h00 : pulse_cnt + 7'(enc_pulse_in);
      enc_idx <= enc_idx + 5'(group_done);
      enc_run <= !(group_done && enc_idx == dcrp_pkg::ENC_DATA_LAST);
    end
  end

  // captured group times, held until overwritten next earth view
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < dcrp_pkg::ENC_DATA_WORDS; i++) begin
        earth_time[i] <= 16'h0000;
      end
    end else if (group_done) begin
      earth_time[enc_idx] <= time_inc;
    end
  end

  // field sequencer decode: entries leave in word-offset order
  wire push = (state != dcrp_pkg::DCRP_IDLE) && fifo_ready;
  wire in_offs = state == dcrp_pkg::DCRP_OFFS;
  wire offs_end = in_offs && idx == dcrp_pkg::OFS_LAST;
  wire enc_end = (state == dcrp_pkg::DCRP_EARTH) && idx == dcrp_pkg::ENC_LAST;
  wire is_photo = slot >= dcrp_pkg::PHOTO_FIRST_SLOT;
  wire photo_pre = is_photo && ((slot - dcrp_pkg::PHOTO_FIRST_SLOT) & 6'h01) != 6'h00;
  wire is_low = slot == dcrp_pkg::DUAL_LOW_A_SLOT || slot == dcrp_pkg::DUAL_LOW_B_SLOT;
  wire is_high = slot == dcrp_pkg::DUAL_HIGH_A_SLOT || slot == dcrp_pkg::DUAL_HIGH_B_SLOT;
  wire dcrp_pkg::dcrp_kind_t ofs_kind = photo_pre ? dcrp_pkg::DCRP_PREAMP : is_photo ? dcrp_pkg::DCRP_POSTAMP :
      is_low ? dcrp_pkg::DCRP_LOW : is_high ? dcrp_pkg::DCRP_HIGH : dcrp_pkg::DCRP_PLAIN;
  wire [15:0] enc_data = (idx < dcrp_pkg::ENC_DATA_LIMIT) ? earth_time[idx[4:0]] : dcrp_pkg::ENC_FILL_VALUE;
  wire [12:0] ofs_bit = dcrp_pkg::OFS_START_BIT + {idx, 3'b000};
  wire [12:0] enc_bit = dcrp_pkg::ENC_START_BIT + {idx[8:0], 4'b0000};
  wire dcrp_pkg::dcrp_word_t push_word = in_offs ? {ofs_kind, ofs_bit, 8'h00, ofs_tbl[idx]} :
      {dcrp_pkg::DCRP_ENC, enc_bit, enc_data};
  wire dcrp_pkg::dcrp_state_t next_state = (state == dcrp_pkg::DCRP_IDLE && scan_start_in) ? dcrp_pkg::DCRP_OFFS :
      (push && offs_end) ? dcrp_pkg::DCRP_EARTH : (push && enc_end) ? dcrp_pkg::DCRP_IDLE : state;

  // sequencer registers; a scan start while busy is ignored
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= dcrp_pkg::DCRP_IDLE;
      busy_out <= 1'b0;
      idx <= 10'h000;
      slot <= 6'h00;
      grp <= 4'h0;
    end else begin
      state <= next_state;
      busy_out <= next_state != dcrp_pkg::DCRP_IDLE;
      if (state == dcrp_pkg::DCRP_IDLE) begin
        idx <= 10'h000;
        slot <= 6'h00;
        grp <= 4'h0;
      end else if (push) begin
        idx <= (offs_end || enc_end) ? 10'h000 : idx + 10'h001;
        slot <= (slot == dcrp_pkg::GROUP_LAST_SLOT) ? 6'h00 : slot + 6'h01;
        grp <= grp + 4'((slot == dcrp_pkg::GROUP_LAST_SLOT) ? 1'b1 : 1'b0);
      end
    end
  end

  // fifo decouples the packer from formatter stalls
  dcrp_fifo #(
    .WIDTH($bits(dcrp_pkg::dcrp_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .s_valid_in(push),
    .s_ready_out(fifo_ready),
    .s_data_in(push_word),
    .m_valid_out(fmt_valid_out),
    .m_ready_in(fmt_ready_in),
    .m_data_out(fmt_word_out)
  );

  // helper state for the checks below
  dcrp_pkg::dcrp_kind_t last_kind;
  logic [10:0] ofs_pushes;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_kind <= dcrp_pkg::DCRP_PLAIN;
      ofs_pushes <= 11'h000;
    end else begin
      if (push) begin
        last_kind <= push_word.kind;
      end
      if (state == dcrp_pkg::DCRP_IDLE) begin
        ofs_pushes <= 11'h000;
      end else if (push && in_offs) begin
        ofs_pushes <= ofs_pushes + 11'h001;
      end
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  a_field_length: assert property ((state == dcrp_pkg::DCRP_EARTH) && $past(in_offs)
    |-> ofs_pushes == 11'h226)
    else $error("offset field did not hold 550 entries");
  a_field_end: assert property (push && offs_end |-> push_word.pkt_bit + 13'h007 == dcrp_pkg::OFS_END_BIT
    ##1 state == dcrp_pkg::DCRP_EARTH)
    else $error("offset field end bit wrong");
  a_entry_position: assert property (push && in_offs
    |-> push_word.pkt_bit - dcrp_pkg::OFS_START_BIT == 13'(ofs_pushes) * 13'h008)
    else $error("entry start bit wrong");
  a_bus_readback: assert property (tbl_wr_in && !tbl_sel_gain_in && addr_ok ##1 tbl_rd_in
    && !tbl_sel_gain_in && tbl_addr_in == $past(tbl_addr_in)
    |=> tbl_rvalid_out && tbl_rdata_out[7:0] == $past(tbl_wdata_in[7:0], 2))
    else $error("bus readback mismatch");
  a_pre_after_post: assert property (push && push_word.kind == dcrp_pkg::DCRP_PREAMP
    |-> last_kind == dcrp_pkg::DCRP_POSTAMP)
    else $error("preamp entry not after postamp");
  a_high_after_low: assert property (push && push_word.kind == dcrp_pkg::DCRP_HIGH
    |-> last_kind == dcrp_pkg::DCRP_LOW)
    else $error("high entry not after low");
  a_scan_sends: assert property (state == dcrp_pkg::DCRP_IDLE && scan_start_in
    |=> busy_out && in_offs && idx == 10'h000)
    else $error("scan start did not begin field");
  a_restore_off_hold: assert property (!dc_restore_on_in && calc_valid_in && !tbl_wr_in && !tbl_rd_in
    ##1 tbl_rd_in && !tbl_sel_gain_in && tbl_addr_in == $past(calc_addr_in) && !tbl_wr_in && !calc_valid_in
    && addr_ok |=> tbl_rvalid_out && tbl_rdata_out[7:0] == $past(ofs_tbl[calc_addr_in], 2))
    else $error("offset changed while computation off");
  a_gain_blank: assert property (tbl_rd_in && tbl_sel_gain_in && addr_ok && bus_photo_slot
    |=> tbl_rdata_out == 16'h0000)
    else $error("gain blank slot not zero");
  a_enc_fill: assert property (push && !in_offs && idx >= dcrp_pkg::ENC_DATA_LIMIT
    |-> push_word.data == 16'h0000)
    else $error("encoder fill word not zero");
  a_enc_group: assert property (group_done |=> enc_idx == $past(enc_idx) + 5'h01 && time_cnt == 16'h0000
    && pulse_cnt == 7'h00)
    else $error("encoder group not closed");
  a_group_order: assert property (push && in_offs |-> {4'h0, slot} == idx % 10'(dcrp_pkg::GROUP_WORDS))
    else $error("group wrap wrong");
  a_group_count: assert property (push && offs_end |-> slot == dcrp_pkg::GROUP_LAST_SLOT
    && grp == dcrp_pkg::GROUP_COUNT - 4'h1)
    else $error("field did not close after ten groups");
  a_enc_start: assert property (earth_start_in |=> enc_run && enc_idx == 5'h00 && pulse_cnt == 7'h00)
    else $error("encoder count did not start");

  c_offs_to_earth: cover property (push && offs_end ##1 state == dcrp_pkg::DCRP_EARTH);
  c_scan_done: cover property (push && enc_end ##1 state == dcrp_pkg::DCRP_IDLE);
  c_fifo_stall: cover property (busy_out && !fifo_ready);
  c_group_capture: cover property (group_done);

endmodule : dcrp_packer
`default_nettype wire

// ===== dcrp_fmt_sink.sv
// packet formatter model: valid/ready sink that logs every word it accepts
`timescale 1ns/1ps
`default_nettype none
module dcrp_fmt_sink (
  input wire logic clk_sys_in,              // system clock
  input wire logic rst_n_in,                // async reset, active low
  input wire logic valid_in,                // stream word valid
  input wire dcrp_pkg::dcrp_word_t word_in, // stream word
  input wire logic hold_in,                 // stall the stream completely
  input wire logic slow_in,                 // accept on every other cycle only
  output logic ready_out                    // accept
);
  dcrp_pkg::dcrp_word_t word_log [0:2047];
  int cnt;
  logic phase;
  // ready moves only at the falling edge, so it is steady around each rising edge
  always @(negedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ready_out <= 1'b0;
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
      ready_out <= ~hold_in & (~slow_in | phase);
    end
  end
  // a word counts as taken only where valid and ready meet at a rising edge
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 0;
    end else if (valid_in === 1'b1 && ready_out) begin
      word_log[cnt] <= word_in;
      cnt <= cnt + 1;
    end
  end
endmodule : dcrp_fmt_sink
`default_nettype wire

// ===== dcrp_packer_test.sv
// self-checking bench for the offset field packer
`timescale 1ns/1ps
`default_nettype none
module dcrp_packer_test;
  logic clk_sys_in, rst_n_in, scan_start_in, dc_restore_on_in, calc_valid_in;
  logic [9:0] calc_addr_in, tbl_addr_in;
  logic [7:0] calc_data_in;
  logic tbl_sel_gain_in, tbl_wr_in, tbl_rd_in, earth_start_in, enc_pulse_in;
  logic [15:0] tbl_wdata_in, tbl_rdata_out, rd;
  logic tbl_rvalid_out, tbl_err_out, busy_out, fmt_valid_out, fmt_ready_in, sink_hold, sink_slow, err;
  dcrp_pkg::dcrp_word_t fmt_word_out;
  logic [7:0] exp_tbl [0:549];
  int fail_count, check_count;

  dcrp_packer #(.FIFO_DEPTH(32)) DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .scan_start_in(scan_start_in), .dc_restore_on_in(dc_restore_on_in), .calc_valid_in(calc_valid_in),
    .calc_addr_in(calc_addr_in), .calc_data_in(calc_data_in), .tbl_sel_gain_in(tbl_sel_gain_in),
    .tbl_wr_in(tbl_wr_in), .tbl_rd_in(tbl_rd_in), .tbl_addr_in(tbl_addr_in), .tbl_wdata_in(tbl_wdata_in),
    .tbl_rdata_out(tbl_rdata_out), .tbl_rvalid_out(tbl_rvalid_out), .tbl_err_out(tbl_err_out),
    .earth_start_in(earth_start_in), .enc_pulse_in(enc_pulse_in), .busy_out(busy_out),
    .fmt_valid_out(fmt_valid_out), .fmt_ready_in(fmt_ready_in), .fmt_word_out(fmt_word_out));
  dcrp_fmt_sink sink (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .valid_in(fmt_valid_out),
    .word_in(fmt_word_out), .hold_in(sink_hold), .slow_in(sink_slow), .ready_out(fmt_ready_in));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task stop_test;
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // one bus access; a read that never answers ends the run
  task bus(input logic wr, input logic gain, input logic [9:0] a, input logic [15:0] wd);
    int i;
    tbl_wr_in = wr;
    tbl_rd_in = ~wr;
    tbl_sel_gain_in = gain;
    tbl_addr_in = a;
    tbl_wdata_in = wd;
    @(negedge clk_sys_in);
    tbl_wr_in = 1'b0;
    tbl_rd_in = 1'b0;
    for (i = 0; i < 3; i++) begin
      if (tbl_rvalid_out === 1'b1 || tbl_err_out === 1'b1) break;
      @(negedge clk_sys_in);
    end
    err = tbl_err_out;
    rd = tbl_rdata_out;
    // one idle edge so the next call never re-raises a strobe in this time step
    @(negedge clk_sys_in);
    if (!wr && i == 3) begin
      check(32'h0, 32'h1);
      stop_test();
    end
  endtask : bus

  function automatic dcrp_pkg::dcrp_kind_t kind_of(input int n);
    int s;
    s = n % 55;
    if (s == 23 || s == 25) return dcrp_pkg::DCRP_LOW;
    if (s == 24 || s == 26) return dcrp_pkg::DCRP_HIGH;
    if (s >= 43) return ((s - 43) % 2 == 0) ? dcrp_pkg::DCRP_POSTAMP : dcrp_pkg::DCRP_PREAMP;
    return dcrp_pkg::DCRP_PLAIN;
  endfunction : kind_of

  // write, then read of the same entry on the very next cycle
  task write_read_b2b(input logic [9:0] a, input logic [7:0] d);
    tbl_sel_gain_in = 1'b0;
    tbl_addr_in = a;
    tbl_wdata_in = {8'h00, d};
    tbl_wr_in = 1'b1;
    @(negedge clk_sys_in);
    tbl_wr_in = 1'b0;
    tbl_rd_in = 1'b1;
    @(negedge clk_sys_in);
    tbl_rd_in = 1'b0;
    exp_tbl[a] = d;
    check({tbl_rvalid_out, tbl_rdata_out}, {1'b1, 8'h00, d});
    @(negedge clk_sys_in);
  endtask : write_read_b2b

  // whole table loaded with junk in the high byte, edges and refusals probed
  task table_access;
    for (int n = 0; n < 550; n++) begin
      exp_tbl[n] = n[7:0] ^ 8'h5a;
      bus(1'b1, 1'b0, 10'(n), {8'hff, exp_tbl[n]});
    end
    write_read_b2b(10'h1f4, 8'h6e);
    bus(1'b0, 1'b0, 10'h000, 16'h0000);
    check(rd, {8'h00, exp_tbl[0]});
    bus(1'b0, 1'b0, 10'h225, 16'h0000);
    check(rd, {8'h00, exp_tbl[549]});
    bus(1'b1, 1'b0, 10'h226, 16'h0011);
    check(err, 1'b1);
    bus(1'b0, 1'b0, 10'h3ff, 16'h0000);
    check(err, 1'b1);
    bus(1'b1, 1'b1, 10'h02a, 16'h0077);
    bus(1'b0, 1'b1, 10'h02a, 16'h0000);
    check(rd, 16'h0077);
    bus(1'b1, 1'b1, 10'h02b, 16'h00c3);
    bus(1'b0, 1'b1, 10'h02b, 16'h0000);
    check(rd, 16'h0000);
  endtask : table_access

  task calc_write(input logic on, input logic [9:0] a, input logic [7:0] d);
    dc_restore_on_in = on;
    calc_valid_in = 1'b1;
    calc_addr_in = a;
    calc_data_in = d;
    @(negedge clk_sys_in);
    calc_valid_in = 1'b0;
    bus(1'b0, 1'b0, a, 16'h0000);
    if (on) exp_tbl[a] = d;
    check(rd, {8'h00, exp_tbl[a]});
  endtask : calc_write

  // 24 groups of 100 pulses five clocks apart, then surplus pulses that must be ignored
  task encoder_timing;
    earth_start_in = 1'b1;
    @(negedge clk_sys_in);
    earth_start_in = 1'b0;
    for (int p = 0; p < 2600; p++) begin
      enc_pulse_in = 1'b1;
      @(negedge clk_sys_in);
      enc_pulse_in = 1'b0;
      repeat (p < 2400 ? 4 : 1) @(negedge clk_sys_in);
    end
  endtask : encoder_timing

  // one scan with the formatter stalled until the fifo refuses, then drained
  task run_scan(input logic slow);
    int base, i;
    dcrp_pkg::dcrp_word_t w;
    base = sink.cnt;
    sink_slow = slow;
    sink_hold = 1'b1;
    scan_start_in = 1'b1;
    @(negedge clk_sys_in);
    scan_start_in = 1'b0;
    check(busy_out, 1'b1);
    repeat (60) @(negedge clk_sys_in);
    check(busy_out, 1'b1);
    check(sink.cnt - base, 32'h0);
    scan_start_in = 1'b1;
    @(negedge clk_sys_in);
    scan_start_in = 1'b0;
    sink_hold = 1'b0;
    for (i = 0; i < 4000 && busy_out !== 1'b0; i++) @(negedge clk_sys_in);
    if (i == 4000) begin
      check(busy_out, 1'b0);
      stop_test();
    end
    repeat (120) @(negedge clk_sys_in);
    check(busy_out, 1'b0);
    check(sink.cnt - base, 32'h274);
    for (int n = 0; n < 550; n++) begin
      w = sink.word_log[base + n];
      check(w, {kind_of(n), dcrp_pkg::OFS_START_BIT + 13'(8*n), 8'h00, exp_tbl[n]});
    end
    check(sink.word_log[base + 549].pkt_bit + 13'h007, 13'h11bf);
    for (int m = 0; m < 78; m++) begin
      w = sink.word_log[base + 550 + m];
      check({w.kind, w.pkt_bit}, {dcrp_pkg::DCRP_ENC, dcrp_pkg::ENC_START_BIT + 13'(16 * m)});
      if (m < 24) check(w.data, (m == 0) ? 16'h0009 : 16'h000a);
      else check(w.data, 16'h0000);
    end
  endtask : run_scan

  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  // a hang anywhere ends the run as a failure
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    fail_count++;
    stop_test();
  end

  initial begin
    {rst_n_in, scan_start_in, dc_restore_on_in, calc_valid_in, calc_addr_in, calc_data_in} = '0;
    {tbl_sel_gain_in, tbl_wr_in, tbl_rd_in, tbl_addr_in, tbl_wdata_in, earth_start_in, enc_pulse_in} = '0;
    sink_hold = 1'b0;
    sink_slow = 1'b0;
    fail_count = 0;
    check_count = 0;
    repeat (16) @(negedge clk_sys_in);
    check({busy_out, fmt_valid_out, tbl_rvalid_out, tbl_err_out}, 4'h0);
    rst_n_in = 1'b1;
    @(negedge clk_sys_in);
    table_access();
    calc_write(1'b1, 10'h064, 8'h3c);
    calc_write(1'b0, 10'h065, 8'hc3);
    encoder_timing();
    run_scan(1'b0);
    // computation off: stale values must go out again unchanged
    calc_write(1'b0, 10'h000, 8'h99);
    run_scan(1'b1);
    stop_test();
  end
endmodule : dcrp_packer_test
`default_nettype wire
